// [rpfc_top.sv]
`timescale 1ns/1ns
module rpfc_top
   import rpfc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire rpfc_bus_t bus,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   output logic branch_req,
   output logic [15:0] branch_target,
   output logic fetch_suppress,
   output logic [15:0] rdata,
   output logic [7:0] patch_control
);
   rpfc_state_t s_q;
   rpfc_state_t s_d;
   logic match0;
   logic match1;

   function automatic logic hits(input logic [15:0] a, input logic [15:0] f, input logic en, input logic v);
      hits = v && en && (a == f);
   endfunction

   // The compare is combinational on the fetch address so the request lands the cycle after the fetch.
   assign match0 = hits(s_q.pa0, fetch_addr, s_q.ctrl[RPFC_EN0_BIT], fetch_valid);
   assign match1 = hits(s_q.pa1, fetch_addr, s_q.ctrl[RPFC_EN1_BIT], fetch_valid);

   always_comb begin
      s_d = s_q;
      // A write while enabled is taken as is; the core may fire on a stale value meanwhile.
      if (bus.wr16 && bus.addr == RPFC_ADDR0_LO) begin
         s_d.pa0 = bus.wdata16;
      end
      if (bus.wr16 && bus.addr == RPFC_ADDR1_LO) begin
         s_d.pa1 = bus.wdata16;
      end
      if (bus.addr == RPFC_CTRL_ADDR) begin
         if (bus.wr8) begin
            s_d.ctrl = (s_q.ctrl & ~RPFC_CTRL_WMASK) | (bus.wdata & RPFC_CTRL_WMASK);
         end else if (bus.bit_wr && RPFC_CTRL_WMASK[bus.bit_sel]) begin
            s_d.ctrl[bus.bit_sel] = bus.bit_val;
         end
      end
      if (bus.hit_clr0) begin
         s_d.ctrl[RPFC_HIT0_BIT] = 1'b0;
      end
      if (bus.hit_clr1) begin
         s_d.ctrl[RPFC_HIT1_BIT] = 1'b0;
      end
      // Set wins over a clear in the same cycle so no hit is lost.
      if (match0) begin
         s_d.ctrl[RPFC_HIT0_BIT] = 1'b1;
      end
      if (match1) begin
         s_d.ctrl[RPFC_HIT1_BIT] = 1'b1;
      end
      s_d.ctrl[7:4] = 4'h0;
      s_d.branch_req = match0 | match1;
      s_d.suppress = match0 | match1;
      s_d.branch_target = RPFC_VECTOR;
      s_d.rdata = 16'h0000;
      if (bus.rd) begin
         unique case (bus.addr)
            RPFC_ADDR0_LO: s_d.rdata = s_q.pa0;
            RPFC_ADDR0_HI: s_d.rdata = {8'h00, s_q.pa0[15:8]};
            RPFC_ADDR1_LO: s_d.rdata = s_q.pa1;
            RPFC_ADDR1_HI: s_d.rdata = {8'h00, s_q.pa1[15:8]};
            RPFC_CTRL_ADDR: s_d.rdata = {8'h00, s_q.ctrl};
            default: s_d.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q.pa0 <= RPFC_ADDR_RESET;
         s_q.pa1 <= RPFC_ADDR_RESET;
         s_q.ctrl <= RPFC_CTRL_RESET;
         s_q.branch_req <= 1'b0;
         s_q.suppress <= 1'b0;
         s_q.branch_target <= RPFC_VECTOR;
         s_q.rdata <= 16'h0000;
      end else begin
         s_q <= s_d;
      end
   end

   assign branch_req = s_q.branch_req;
   assign branch_target = s_q.branch_target;
   assign fetch_suppress = s_q.suppress;
   assign rdata = s_q.rdata;
   assign patch_control = s_q.ctrl;

   property p_hit_req;
      @(posedge clk) disable iff (!rst_b) (match0 || match1) |=> branch_req && fetch_suppress;
   endproperty
   a_hit_req: assert property (p_hit_req) else $error("match without branch request");

   property p_no_spurious;
      @(posedge clk) disable iff (!rst_b) !(match0 || match1) |=> !branch_req;
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("branch request without match");

   property p_flag0;
      @(posedge clk) disable iff (!rst_b) match0 |=> patch_control[RPFC_HIT0_BIT];
   endproperty
   a_flag0: assert property (p_flag0) else $error("hit flag 0 not set");

   property p_flag1;
      @(posedge clk) disable iff (!rst_b) match1 |=> patch_control[RPFC_HIT1_BIT];
   endproperty
   a_flag1: assert property (p_flag1) else $error("hit flag 1 not set");

   property p_ro;
      @(posedge clk) disable iff (!rst_b) (!match0 && !bus.hit_clr0) |=> patch_control[0] == $past(patch_control[0]);
   endproperty
   a_ro: assert property (p_ro) else $error("read-only bit changed by write");

   property p_wr16;
      @(posedge clk) disable iff (!rst_b) (bus.wr16 && bus.addr == RPFC_ADDR0_LO) |=> s_q.pa0 == $past(bus.wdata16);
   endproperty
   a_wr16: assert property (p_wr16) else $error("address register 0 not loaded");

   property p_target;
      @(posedge clk) disable iff (!rst_b) branch_req |-> branch_target == RPFC_VECTOR;
   endproperty
   a_target: assert property (p_target) else $error("wrong branch target");

   property p_upper;
      @(posedge clk) disable iff (!rst_b) patch_control[7:4] == 4'h0;
   endproperty
   a_upper: assert property (p_upper) else $error("upper control bits nonzero");

   property p_en_off;
      @(posedge clk) disable iff (!rst_b) (!patch_control[RPFC_EN0_BIT] && !patch_control[RPFC_EN1_BIT]) |=> !branch_req;
   endproperty
   a_en_off: assert property (p_en_off) else $error("request while disabled");

   // A matching fetch is followed by one combined request and suppress pulse.
   sequence s_fetch_hit;
      fetch_valid && (match0 || match1);
   endsequence

   sequence s_req_pulse;
      branch_req && fetch_suppress && branch_target == RPFC_VECTOR;
   endsequence

   property p_req_seq;
      @(posedge clk) disable iff (!rst_b) s_fetch_hit |=> s_req_pulse;
   endproperty
   a_req_seq: assert property (p_req_seq) else $error("fetch hit not followed by branch");

   property p_suppress_eq;
      @(posedge clk) disable iff (!rst_b) fetch_suppress == branch_req;
   endproperty
   a_suppress_eq: assert property (p_suppress_eq) else $error("suppress and request differ");

   property p_wr16_1;
      @(posedge clk) disable iff (!rst_b) (bus.wr16 && bus.addr == RPFC_ADDR1_LO) |=> s_q.pa1 == $past(bus.wdata16);
   endproperty
   a_wr16_1: assert property (p_wr16_1) else $error("address register 1 not loaded");

   property p_hold0;
      @(posedge clk) disable iff (!rst_b) !(bus.wr16 && bus.addr == RPFC_ADDR0_LO) |=> s_q.pa0 == $past(s_q.pa0);
   endproperty
   a_hold0: assert property (p_hold0) else $error("address register 0 changed without word write");

   property p_hold1;
      @(posedge clk) disable iff (!rst_b) !(bus.wr16 && bus.addr == RPFC_ADDR1_LO) |=> s_q.pa1 == $past(s_q.pa1);
   endproperty
   a_hold1: assert property (p_hold1) else $error("address register 1 changed without word write");

   property p_ro2;
      @(posedge clk) disable iff (!rst_b) (!match1 && !bus.hit_clr1) |=> patch_control[2] == $past(patch_control[2]);
   endproperty
   a_ro2: assert property (p_ro2) else $error("read-only bit 2 changed by write");

   property p_en_byte;
      @(posedge clk) disable iff (!rst_b) (bus.wr8 && bus.addr == RPFC_CTRL_ADDR) |=>
         patch_control[RPFC_EN0_BIT] == $past(bus.wdata[RPFC_EN0_BIT]);
   endproperty
   a_en_byte: assert property (p_en_byte) else $error("byte write missed enable 0");

   // Byte writes take priority, so the bit write check only looks when no byte write is present.
   property p_bit_wr;
      @(posedge clk) disable iff (!rst_b) (bus.bit_wr && !bus.wr8 && bus.addr == RPFC_CTRL_ADDR &&
         bus.bit_sel == 3'h1) |=> patch_control[RPFC_EN0_BIT] == $past(bus.bit_val);
   endproperty
   a_bit_wr: assert property (p_bit_wr) else $error("bit write missed enable 0");

   property p_rd_ctrl;
      @(posedge clk) disable iff (!rst_b) (bus.rd && bus.addr == RPFC_CTRL_ADDR) |=>
         rdata == {8'h00, $past(patch_control)};
   endproperty
   a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read returned wrong value");

   property p_rd_idle;
      @(posedge clk) disable iff (!rst_b) !bus.rd |=> rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");

   // A clear only wins when no new hit arrives in the same cycle.
   property p_clear0;
      @(posedge clk) disable iff (!rst_b) (bus.hit_clr0 && !match0) |=> !patch_control[RPFC_HIT0_BIT];
   endproperty
   a_clear0: assert property (p_clear0) else $error("hit flag 0 not cleared");
endmodule

// [rpfc_pkg.sv]
package rpfc_pkg;
   localparam logic [15:0] RPFC_ADDR0_LO = 16'hFF38;
   localparam logic [15:0] RPFC_ADDR0_HI = 16'hFF39;
   localparam logic [15:0] RPFC_ADDR1_LO = 16'hFF3A;
   localparam logic [15:0] RPFC_ADDR1_HI = 16'hFF3B;
   localparam logic [15:0] RPFC_CTRL_ADDR = 16'hFF3C;
   localparam logic [15:0] RPFC_VECTOR = 16'hF7FD;
   localparam logic [15:0] RPFC_ADDR_RESET = 16'h0000;
   localparam logic [7:0] RPFC_CTRL_RESET = 8'h00;
   localparam int RPFC_HIT0_BIT = 0;
   localparam int RPFC_EN0_BIT = 1;
   localparam int RPFC_HIT1_BIT = 2;
   localparam int RPFC_EN1_BIT = 3;
   localparam logic [7:0] RPFC_CTRL_WMASK = 8'h0A;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic [15:0] wdata16;
      logic wr8;
      logic wr16;
      logic bit_wr;
      logic [2:0] bit_sel;
      logic bit_val;
      logic rd;
      logic hit_clr0;
      logic hit_clr1;
   } rpfc_bus_t;

   typedef struct packed {
      logic [15:0] pa0;
      logic [15:0] pa1;
      logic [7:0] ctrl;
      logic branch_req;
      logic suppress;
      logic [15:0] branch_target;
      logic [15:0] rdata;
   } rpfc_state_t;
endpackage

// [rpfc_cpu_model.sv]
`timescale 1ns/1ns
module rpfc_cpu_model(
   input wire logic clk,
   input wire logic go,
   input wire logic [15:0] start,
   input wire logic branch_req,
   input wire logic [15:0] branch_target,
   output logic fetch_valid,
   output logic [15:0] fetch_addr
);
   initial {fetch_valid, fetch_addr} = '0;
   // A forced branch replaces the fetch after next; the fetch right after the match still goes to the next address.
   // The model moves on the rising edge so it never races the bench, which drives go on the falling edge.
   always @(posedge clk) begin
      fetch_valid <= go;
      fetch_addr <= !go ? start : branch_req ? branch_target : fetch_addr + 16'h0001;
   end
endmodule

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top;
   import rpfc_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, go = 1'b0, br, sup, fv;
   logic [15:0] fa, st = 16'h0000, tgt, rdata, a0 = 16'h0000, a1 = 16'h0000;
   logic [7:0] pc;
   logic [1:0] en = 2'b00, pend = 2'b00;
   rpfc_bus_t b = '0;
   int failures = 0, checked = 0, cyc = 0;
   initial forever #5 clk = ~clk;
   rpfc_top DUT(.clk(clk), .rst_b(rst_b), .bus(b), .fetch_valid(fv), .fetch_addr(fa), .branch_req(br),
      .branch_target(tgt), .fetch_suppress(sup), .rdata(rdata), .patch_control(pc));
   rpfc_cpu_model cpu(.clk(clk), .go(go), .start(st), .branch_req(br), .branch_target(tgt),
      .fetch_valid(fv), .fetch_addr(fa));
   function automatic logic [1:0] hits(logic [15:0] f);
      return {en[1] && f == a1, en[0] && f == a0};
   endfunction
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      checked++;
      if (e !== g) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic stop_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Kind k: bit0 byte write, bit1 word write, bit2 bit write, bit3 read, bits 5:4 hit clears.
   task automatic op(logic [15:0] a, logic [15:0] d, logic [5:0] k);
      @(negedge clk);
      b = '{addr: a, wdata: d[7:0], wdata16: d, wr8: k[0], wr16: k[1], bit_wr: k[2], bit_sel: d[2:0],
         bit_val: d[3], rd: k[3], hit_clr0: k[4], hit_clr1: k[5]};
      @(negedge clk);
      b = '0;
      if (k[1] && a == RPFC_ADDR0_LO) a0 = d;
      if (k[1] && a == RPFC_ADDR1_LO) a1 = d;
      if (k[0]) en = {d[3], d[1]};
      if (k[2]) en[d[1]] = d[3];
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      pend <= fv === 1'b1 ? hits(fa) : 2'b00;
      if (cyc == 5000) begin
         failures++;
         stop_test();
      end
   end
   always @(negedge clk) begin
      if (rst_b) begin
         chk("branch", |pend, br);
         chk("suppress", |pend, sup);
         if (|pend) chk("target", RPFC_VECTOR, tgt);
         if (|pend) chk("hits", {pend[1], 1'b0, pend[0]}, pc[2:0] & {pend[1], 1'b0, pend[0]});
      end
   end
   initial begin
      void'($urandom(32'hE2AC2C15));
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      op(RPFC_ADDR0_LO, 0, 8); chk("pa0", RPFC_ADDR_RESET, rdata);
      op(RPFC_ADDR1_LO, 0, 8); chk("pa1", RPFC_ADDR_RESET, rdata);
      op(RPFC_CTRL_ADDR, 0, 8); chk("ctrl", RPFC_CTRL_RESET, rdata);
      op(RPFC_CTRL_ADDR, 16'h00FF, 1); op(RPFC_CTRL_ADDR, 0, 8); chk("ctrl", 16'h000A, rdata);
      for (int i = 0; i < 8; i++) begin
         op(RPFC_CTRL_ADDR, $urandom & 16'h00F5, 1);
         op(RPFC_ADDR0_LO, 16'h0080 + $urandom_range(16'h7000), 2);
         op(RPFC_ADDR1_LO, 16'h0080 + $urandom_range(16'h7000), 2);
         op(RPFC_ADDR0_LO, 0, 8); chk("pa0", a0, rdata);
         op(RPFC_ADDR1_LO, 0, 8); chk("pa1", a1, rdata);
         op(RPFC_CTRL_ADDR, {i[0], 3'd1}, 4);
         op(RPFC_CTRL_ADDR, {i[1], 3'd3}, 4);
         for (int j = 0; j < 2; j++) begin
            st = (j ? a1 : a0) - 16'h0003;
            @(negedge clk);
            go = 1'b1;
            repeat (8) @(negedge clk);
            go = 1'b0;
            @(negedge clk);
         end
         op(RPFC_CTRL_ADDR, 0, 6'h30); op(RPFC_CTRL_ADDR, 0, 8);
         chk("ctrl", {en[1], 1'b0, en[0], 1'b0}, rdata);
         $display("test %0d done", i);
      end
      stop_test();
   end
endmodule
